// file: pkg/frg_pkg.sv
// Package for the flash ready and reset guard host controller.
// Assumes a 250 MHz mclk and an APB slave port for software.
package frg_pkg;
  // APB register offsets
  localparam logic [11:0] CTRL_OFF = 12'h000;
  localparam logic [11:0] CMD_OFF = 12'h004;
  localparam logic [11:0] STAT_OFF = 12'h008;
  localparam logic [11:0] ISTAT_OFF = 12'h00c;
  localparam logic [11:0] IMASK_OFF = 12'h010;
  localparam logic [11:0] RDATA_OFF = 12'h014;
  // Control register fields
  localparam int CTRL_RESET_BIT = 0;
  localparam int CTRL_ALTER_BIT = 1;
  localparam int CTRL_MODE_LSB = 4;
  // Command codes
  localparam logic [7:0] CMD_READ_ARRAY = 8'hff;
  // Command kinds
  localparam logic [1:0] KIND_SINGLE = 2'h0;
  localparam logic [1:0] KIND_ALTER = 2'h1;
  localparam logic [1:0] KIND_READ = 2'h2;
  // Interrupt bits
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_ABORT_BIT = 1;
  localparam int IRQ_REFUSED_BIT = 2;
  localparam logic [2:0] IRQ_RESET = 3'h0;
  localparam logic [2:0] CTRL_RESET = 3'h0;
  // Timing
  localparam int CLK_MHZ = 250;
  localparam int STROBE_NS = 100;
  localparam int STROBE_CYC = (STROBE_NS * CLK_MHZ + 999) / 1000;
  localparam int RESET_NS = 25000;
  localparam int RESET_CYC = (RESET_NS * CLK_MHZ + 999) / 1000;
  localparam logic [15:0] CNT_ZERO = 16'h0000;

  typedef struct packed {
    logic chip_select_0;
    logic chip_select_1;
    logic chip_select_2;
    logic oe_n;
    logic we_n;
    logic reset_powerdown_n;
  } frg_ctl_t;
endpackage : frg_pkg

// file: rtl/frg_sync.sv
// Two-flop synchroniser for pins from the flash.
// Assumes inputs are asynchronous to mclk.
`timescale 1ns/1ps
`default_nettype none
module frg_sync (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic din,
  output logic dout
);
  logic meta_reg;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      meta_reg <= 1'b1;
      dout <= 1'b1;
    end else begin
      meta_reg <= din;
      dout <= meta_reg;
    end
  end
endmodule : frg_sync
`default_nettype wire

// file: rtl/frg_host.sv
// Host controller driving a parallel NOR flash command interface.
// Assumes an external pull-up on the completion indicator and on the
// shared data bus; APB slave for software control.
//
// The address map and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module frg_host (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  input wire logic power_ok_signal,
  input wire logic completion_indicator,
  output frg_pkg::frg_ctl_t flash_ctl,
  output logic [23:0] flash_addr,
  input wire logic [7:0] flash_data_in,
  output logic [7:0] flash_data_out,
  output logic flash_data_oe
);
  typedef enum logic [2:0] {
    ST_IDLE, ST_SETUP, ST_STROBE, ST_GAP, ST_READ, ST_BUSY, ST_RESET
  } frg_state_t;

  frg_state_t state_reg;
  logic [2:0] ctrl_reg;
  logic [7:0] cmd_code_reg;
  logic [7:0] cmd_data_reg;
  logic [23:0] cmd_addr_reg;
  logic [1:0] cmd_kind_reg;
  logic phase_reg;
  logic [15:0] cnt_reg;
  logic [2:0] istat_reg;
  logic [2:0] imask_reg;
  logic [7:0] rdata_reg;
  logic need_read_array_reg;
  logic ind_sync;
  logic pwr_sync;
  logic busy_seen_reg;
  logic apb_wr;
  logic go;
  logic [2:0] ev;
  logic reset_req;

  // Indicator synchronised; device drives it regardless of selects
  frg_sync u_ind (
    .mclk(mclk),
    .arst_n(arst_n),
    .din(completion_indicator),
    .dout(ind_sync)
  );
  frg_sync u_pwr (
    .mclk(mclk),
    .arst_n(arst_n),
    .din(power_ok_signal),
    .dout(pwr_sync)
  );

  function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
    return a == o;
  endfunction : hit

  assign apb_wr = psel && penable && pwrite;
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign go = apb_wr && hit(paddr, frg_pkg::CMD_OFF) && state_reg == ST_IDLE;
  // Reset follows power-ok or the software reset bit
  assign reset_req = !pwr_sync || ctrl_reg[frg_pkg::CTRL_RESET_BIT];

  always_comb begin
    prdata = 32'h0000_0000;
    if (hit(paddr, frg_pkg::CTRL_OFF)) prdata[2:0] = ctrl_reg;
    else if (hit(paddr, frg_pkg::STAT_OFF)) begin
      prdata[0] = state_reg != ST_IDLE;
      prdata[1] = !ind_sync;
      prdata[2] = need_read_array_reg;
      prdata[3] = state_reg == ST_RESET;
    end else if (hit(paddr, frg_pkg::ISTAT_OFF)) prdata[2:0] = istat_reg;
    else if (hit(paddr, frg_pkg::IMASK_OFF)) prdata[2:0] = imask_reg;
    else if (hit(paddr, frg_pkg::RDATA_OFF)) prdata[7:0] = rdata_reg;
    else if (hit(paddr, frg_pkg::CMD_OFF)) begin
      prdata[7:0] = cmd_code_reg;
      prdata[15:8] = cmd_data_reg;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) ctrl_reg <= frg_pkg::CTRL_RESET;
    else if (apb_wr && hit(paddr, frg_pkg::CTRL_OFF)) ctrl_reg <= pwdata[2:0];
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) imask_reg <= frg_pkg::IRQ_RESET;
    else if (apb_wr && hit(paddr, frg_pkg::IMASK_OFF))
      imask_reg <= pwdata[2:0];
  end

  // Command register: code [7:0], data [15:8], kind [17:16]; addr in [31:18]
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cmd_code_reg <= frg_pkg::CMD_READ_ARRAY;
      cmd_data_reg <= 8'h00;
      cmd_addr_reg <= 24'h000000;
      cmd_kind_reg <= frg_pkg::KIND_SINGLE;
    end else if (go) begin
      cmd_code_reg <= pwdata[7:0];
      cmd_data_reg <= pwdata[15:8];
      cmd_kind_reg <= pwdata[17:16];
      cmd_addr_reg <= {10'h000, pwdata[31:18]};
    end
  end

  localparam logic [15:0] CNT_ONE = 16'h0001;

  // Sequencer: one strobe per write, alters use setup then confirm
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= ST_IDLE;
      phase_reg <= 1'b0;
      cnt_reg <= frg_pkg::CNT_ZERO;
      busy_seen_reg <= 1'b0;
      rdata_reg <= 8'h00;
    end else if (reset_req && state_reg != ST_RESET) begin
      state_reg <= ST_RESET;
      cnt_reg <= 16'(frg_pkg::RESET_CYC);
    end else begin
      case (state_reg)
        ST_IDLE: begin
          phase_reg <= 1'b0;
          if (go) state_reg <= ST_SETUP;
        end
        ST_SETUP: begin
          // Alteration refused while program-enable is off
          // Kind comes from the latched command; the bus has moved on
          if (cmd_kind_reg == frg_pkg::KIND_ALTER &&
              !ctrl_reg[frg_pkg::CTRL_ALTER_BIT]) state_reg <= ST_IDLE;
          else begin
            state_reg <= ST_STROBE;
            cnt_reg <= 16'(frg_pkg::STROBE_CYC);
          end
        end
        ST_STROBE: begin
          if (cnt_reg != CNT_ONE) cnt_reg <= cnt_reg - 16'h0001;
          else begin
            state_reg <= ST_GAP;
            cnt_reg <= 16'(frg_pkg::STROBE_CYC);
          end
        end
        ST_GAP: begin
          if (cnt_reg != CNT_ONE) cnt_reg <= cnt_reg - 16'h0001;
          else if (cmd_kind_reg == frg_pkg::KIND_ALTER && !phase_reg) begin
            phase_reg <= 1'b1;
            state_reg <= ST_STROBE;
            cnt_reg <= 16'(frg_pkg::STROBE_CYC);
          end else if (cmd_kind_reg == frg_pkg::KIND_ALTER) begin
            state_reg <= ST_BUSY;
            busy_seen_reg <= 1'b0;
          end else if (cmd_kind_reg == frg_pkg::KIND_READ) begin
            state_reg <= ST_READ;
            cnt_reg <= 16'(frg_pkg::STROBE_CYC);
          end else state_reg <= ST_IDLE;
        end
        ST_READ: begin
          if (cnt_reg != CNT_ONE) cnt_reg <= cnt_reg - 16'h0001;
          else begin
            rdata_reg <= flash_data_in;
            state_reg <= ST_IDLE;
          end
        end
        ST_BUSY: begin
          // Wait for the indicator to go low, then released
          if (!ind_sync) busy_seen_reg <= 1'b1;
          else if (busy_seen_reg) state_reg <= ST_IDLE;
        end
        ST_RESET: begin
          if (cnt_reg != frg_pkg::CNT_ZERO) cnt_reg <= cnt_reg - 16'h0001;
          // Indicator is not trusted here; the device floats it in reset
          else if (!reset_req) state_reg <= ST_IDLE;
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // After an alter the array needs a read-array command first
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) need_read_array_reg <= 1'b0;
    else if (state_reg == ST_BUSY) need_read_array_reg <= 1'b1;
    else if (state_reg == ST_RESET) need_read_array_reg <= 1'b0;
    else if (go && pwdata[7:0] == frg_pkg::CMD_READ_ARRAY)
      need_read_array_reg <= 1'b0;
  end

  // Events: done, abort of a running alter, refused alter
  always_comb begin
    ev = 3'h0;
    ev[frg_pkg::IRQ_DONE_BIT] = state_reg == ST_BUSY && ind_sync &&
      busy_seen_reg;
    ev[frg_pkg::IRQ_ABORT_BIT] = state_reg == ST_BUSY && reset_req;
    ev[frg_pkg::IRQ_REFUSED_BIT] = state_reg == ST_SETUP && !reset_req &&
      cmd_kind_reg == frg_pkg::KIND_ALTER &&
      !ctrl_reg[frg_pkg::CTRL_ALTER_BIT];
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) istat_reg <= frg_pkg::IRQ_RESET;
    else if (apb_wr && hit(paddr, frg_pkg::ISTAT_OFF))
      istat_reg <= (istat_reg & ~pwdata[2:0]) | ev;
    else istat_reg <= istat_reg | ev;
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) irq <= 1'b0;
    else irq <= |(istat_reg & imask_reg);
  end

  // Pin drive: selects only during a strobe or read, strobe only on writes
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      flash_ctl <= '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
      flash_addr <= 24'h000000;
      flash_data_out <= 8'h00;
      flash_data_oe <= 1'b0;
    end else begin
      flash_ctl.reset_powerdown_n <= state_reg != ST_RESET &&
        !reset_req;
      flash_ctl.chip_select_0 <= (state_reg == ST_STROBE ||
        state_reg == ST_READ) && !reset_req;
      flash_ctl.chip_select_1 <= 1'b0;
      flash_ctl.chip_select_2 <= 1'b0;
      flash_ctl.we_n <= !(state_reg == ST_STROBE && !reset_req);
      flash_ctl.oe_n <= !(state_reg == ST_READ && !reset_req);
      flash_addr <= cmd_addr_reg;
      flash_data_out <= (cmd_kind_reg == frg_pkg::KIND_ALTER && phase_reg) ?
        cmd_data_reg : cmd_code_reg;
      flash_data_oe <= (state_reg == ST_STROBE || state_reg == ST_GAP) &&
        !reset_req;
    end
  end
endmodule : frg_host
`default_nettype wire

// file: dv/frg_host_monitor.sv
// Port checker for frg_host, attached by bind.
// Assumes one mclk domain with arst_n as its reset.
`timescale 1ns/1ps
`default_nettype none
module frg_host_chk (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic power_ok_signal,
  input wire logic completion_indicator,
  input wire frg_pkg::frg_ctl_t flash_ctl,
  input wire logic flash_data_oe
);
  logic [15:0] low_reg;
  logic armed_reg;
  wire rp_n = flash_ctl.reset_powerdown_n;
  wire we_n = flash_ctl.we_n;
  wire cs0 = flash_ctl.chip_select_0;
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  // Armed only once the pin was seen high, so power-up release is exempt
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      low_reg <= 16'h0000;
      armed_reg <= 1'b0;
    end else begin
      low_reg <= rp_n ? 16'h0000 : low_reg + 16'h0001;
      armed_reg <= armed_reg | rp_n;
    end
  end
  AST_PREADY: assert property (psel && penable |-> pready)
    else $error("access phase without ready");
  AST_WE_GATED: assert property (!we_n |-> cs0 && rp_n)
    else $error("strobe while deselected");
  AST_WE_HELD: assert property ($fell(we_n) |-> (!we_n && cs0) [*8])
    else $error("strobe too short");
  AST_NO_FIGHT: assert property (flash_data_oe |-> flash_ctl.oe_n)
    else $error("bus driven during read");
  AST_BUSY_QUIET: assert property (!completion_indicator [*3] |-> we_n)
    else $error("command written while busy");
  AST_PWR_FORCE: assert property (!power_ok_signal [*5] |-> !rp_n)
    else $error("power fail did not reset flash");
  AST_HOLD: assert property ($rose(rp_n) && armed_reg |->
    low_reg >= frg_pkg::RESET_CYC - 1)
    else $error("flash reset too short");
  AST_RST_QUIET: assert property (!rp_n |-> !flash_data_oe)
    else $error("bus driven in flash reset");
  C_WRITE: cover property ($fell(we_n));
  C_BUSY: cover property ($fell(completion_indicator));
  C_RESET: cover property ($fell(rp_n));
endmodule : frg_host_chk
bind frg_host frg_host_chk u_chk (.mclk(mclk), .arst_n(arst_n),
  .psel(psel), .penable(penable), .pready(pready),
  .power_ok_signal(power_ok_signal),
  .completion_indicator(completion_indicator),
  .flash_ctl(flash_ctl), .flash_data_oe(flash_data_oe));
`default_nettype wire

// file: dv/frg_flash_model.sv
// Behavioural flash device facing frg_host.
// Assumes mclk samples the control pins and data and paces its internal timers.
`timescale 1ns/1ps
`default_nettype none
module frg_flash_model #(parameter int BUSY_CYC = 200) (
  input wire logic mclk,
  input wire frg_pkg::frg_ctl_t ctl,
  input wire logic [7:0] din,
  input wire logic program_enable_supply_ok,
  output logic sts_low,
  output logic [7:0] dout,
  output logic [7:0] array_byte,
  output int strobes
);
  logic rd_mode = 1'b1, setup = 1'b0, wl = 1'b0;
  logic [7:0] wd, pend, status = 8'h80;
  int busy = 0, abort = 0;
  wire en = ctl.chip_select_0 && ctl.reset_powerdown_n;
  assign sts_low = busy > 0 || abort > 0;
  assign dout = en && !ctl.oe_n ? (rd_mode ? array_byte : status)
    : 8'hff;
  initial begin
    array_byte = 8'h00;
    strobes = 0;
  end
  always @(posedge mclk) begin
    if (abort > 0) abort--;
    if (!ctl.reset_powerdown_n) begin
      abort = busy > 0 ? 20 : abort;
      busy = 0;
      status = 8'h00;
      rd_mode = 1'b1;
      setup = 1'b0;
      wl = 1'b0;
    end else if (!ctl.we_n && en) begin
      wl = 1'b1;
      wd = din;
    end else if (wl) begin
      // Latched on strobe release, whatever the indicator shows
      wl = 1'b0;
      strobes++;
      if (setup) begin
        setup = 1'b0;
        pend = wd;
        if (program_enable_supply_ok) busy = BUSY_CYC;
      end else begin
        rd_mode = wd == 8'hff;
        setup = wd == 8'h40;
      end
    end else if (busy > 0) begin
      busy--;
      if (busy == 0) array_byte = pend;
    end
  end
endmodule : frg_flash_model
`default_nettype wire

// file: dv/frg_host_bench.sv
// Bench for frg_host against the behavioural flash.
// Assumes pull-ups on indicator and data bus are resolved here.
`timescale 1ns/1ps
`default_nettype none
module frg_host_bench;
  logic mclk, arst_n, psel, penable, pwrite, pok, pready, irq, oe, sl;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0] dq_o, m_o, arr;
  logic [23:0] fa;
  frg_pkg::frg_ctl_t ctl;
  int errors, compares, cyc, strobes;
  wire ind = !sl;
  wire [7:0] bus = (oe ? dq_o : 8'hff) & m_o;
  frg_host u_dut (.mclk(mclk), .arst_n(arst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(), .irq(irq),
    .power_ok_signal(pok), .completion_indicator(ind), .flash_ctl(ctl),
    .flash_addr(fa), .flash_data_in(bus), .flash_data_out(dq_o),
    .flash_data_oe(oe));
  frg_flash_model u_flash (.mclk(mclk), .ctl(ctl), .din(bus),
    .program_enable_supply_ok(1'b1), .sts_low(sl), .dout(m_o), .array_byte(arr),
    .strobes(strobes));
  task automatic print_verdict;
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic [11:0] a, input logic w,
    input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask : apb
  task automatic idle;
    rd = 32'h1;
    while (rd[0] !== 1'b0 || rd[3] !== 1'b0)
      apb(frg_pkg::STAT_OFF, 1'b0, 32'h0);
  endtask : idle
  task automatic t_refuse;
    apb(12'h040, 1'b0, 32'h0);
    apb(frg_pkg::ISTAT_OFF, 1'b0, 32'h0);
    chk(rd, 32'h0);
    apb(frg_pkg::IMASK_OFF, 1'b1, 32'h4);
    apb(frg_pkg::CMD_OFF, 1'b1, 32'h0001_a540);
    apb(frg_pkg::ISTAT_OFF, 1'b0, 32'h0);
    chk(rd & 32'h7, 32'h4);
    chk({31'h0, irq}, 32'h1);
    chk(strobes, 0);
    apb(frg_pkg::ISTAT_OFF, 1'b1, 32'h4);
    apb(frg_pkg::IMASK_OFF, 1'b0, 32'h0);
    chk({rd[31:1], irq}, 32'h4);
  endtask : t_refuse
  task automatic t_alter;
    apb(frg_pkg::CTRL_OFF, 1'b1, 32'h2);
    apb(frg_pkg::CMD_OFF, 1'b1, 32'h0001_a540);
    idle();
    chk(strobes, 2);
    chk({24'h0, arr}, 32'ha5);
    chk(rd & 32'h4, 32'h4);
    apb(frg_pkg::CMD_OFF, 1'b1, 32'h0002_00ff);
    idle();
    apb(frg_pkg::RDATA_OFF, 1'b0, 32'h0);
    chk(rd & 32'hff, 32'ha5);
  endtask : t_alter
  task automatic t_abort;
    apb(frg_pkg::CMD_OFF, 1'b1, 32'h0001_3c40);
    while (ind !== 1'b0) @(posedge mclk);
    // Indicator falls during the gap; let the host reach its busy wait
    repeat (30) @(posedge mclk);
    pok <= 1'b0;
    repeat (8) @(posedge mclk);
    pok <= 1'b1;
    apb(frg_pkg::STAT_OFF, 1'b0, 32'h0);
    chk(rd & 32'h8, 32'h8);
    idle();
    apb(frg_pkg::ISTAT_OFF, 1'b0, 32'h0);
    chk(rd & 32'h2, 32'h2);
    chk({24'h0, arr}, 32'ha5);
    apb(frg_pkg::CMD_OFF, 1'b1, 32'h0002_0070);
    idle();
    apb(frg_pkg::RDATA_OFF, 1'b0, 32'h0);
    chk(rd & 32'hff, 32'h0);
    apb(frg_pkg::CMD_OFF, 1'b1, 32'h0001_3c40);
    idle();
    chk({24'h0, arr}, 32'h3c);
  endtask : t_abort
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 40000) begin
      errors++;
      print_verdict();
    end
  end
  initial begin
    {arst_n, psel, penable, pwrite} = 4'h0;
    pok = 1'b1;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (5) @(posedge mclk);
    arst_n <= 1'b1;
    @(posedge mclk);
    t_refuse();
    t_alter();
    t_abort();
    print_verdict();
  end
endmodule : frg_host_bench
`default_nettype wire
